// file: core/adc_mode_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module adc_mode_ctrl
  import adc_mode_pkg::*;
#(
  parameter int WAKE_CYC = OSC_WAKE_CYC
) (
  // system clock and reset
  input wire logic I_CLK,
  input wire logic I_RST,
  // serial link, clocked by the host
  input wire logic I_SCLK,
  input wire logic I_CS_N,
  input wire logic I_DIN,
  output logic O_DOUT_RDY_N,
  output logic O_DOUT_OE,
  // sync pin
  input wire logic I_SYNC_N,
  // settings
  input wire logic I_CFG_WR,
  input wire cfg_s I_CFG,
  output cfg_s O_CFG,
  // converter core
  input wire logic I_CONV_DONE,
  input wire logic [23:0] I_CONV_DATA,
  output logic [3:0] O_CHAN,
  output logic O_MOD_RESET,
  output logic O_POWER_DOWN,
  output logic O_OSC_EN,
  // clock source
  input wire logic I_INT_OSC_CLK,
  output logic [1:0] O_CLKSRC_SEL,
  output logic O_XTAL_EN,
  output logic O_CLKB_OUT,
  output logic O_CLKB_OE
);
  localparam int WW = $clog2(WAKE_CYC + 1);

  // next enabled channel above cur; wraps to lowest with flag set
  function automatic logic [4:0] next_chan(input logic [7:0] en, input logic [3:0] cur);
    logic [4:0] r;
    r = 5'h10;
    for (int i = 7; i >= 0; i--) begin
      if (en[i]) r = {1'b1, 4'(i)};
    end
    for (int i = 7; i >= 0; i--) begin
      if (en[i] && 4'(i) > cur) r = {1'b0, 4'(i)};
    end
    return r;
  endfunction

  // ---------------- system clock domain ----------------
  cfg_s cfg_ff; // live settings
  seq_state_e st_ff; // sequencer state
  logic [3:0] chan_ff; // channel converting
  logic [WW-1:0] wake_cnt_ff; // oscillator wake countdown
  logic mod_hold_ff; // sync hold, released on falling edge
  logic sync_s1, sync_s2, sync_d_ff; // sync pin synchroniser
  logic busy_s1, busy_s2; // data access level from link
  logic rdt_s1, rdt_s2, rdt_s3; // read-done toggle from link
  logic rst_s1, rst_s2, rst_s3; // ones-reset toggle from link
  logic busy_ff; // link side: one-shot data access in progress
  logic rd_tog_ff, rst_tog_ff; // link side: events toward system clock
  logic frame_ff; // link side: high from a frame's first edge until select rises
  logic soft_rst_ff; // one-cycle reset from serial input
  logic upd_pend_ff; // result waits one cycle behind ready
  logic [23:0] hold_data_ff; // captured conversion
  logic [3:0] hold_chan_ff; // its channel
  result_s data_reg_ff; // data register
  logic [1:0] new_tog_ff; // gray count of data updates; four unclocked updates alias
  logic rdy_n_ff; // ready flag, low when fresh data
  logic conv_take, rd_done, sync_rise;
  logic [4:0] nx_chan, first_cfg, first_new;
  result_s nxt_result;

  assign conv_take = (st_ff == ST_CONV) && I_CONV_DONE;
  assign rd_done = rdt_s2 ^ rdt_s3;
  assign sync_rise = sync_s2 && !sync_d_ff;
  assign nx_chan = next_chan(cfg_ff.chan_en, chan_ff);
  assign first_cfg = next_chan(cfg_ff.chan_en, 4'hF);
  assign first_new = next_chan(I_CFG.chan_en, 4'hF);

  // crossings into the system clock; first stages feed only second
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      {sync_s1, sync_s2, sync_d_ff} <= 3'h7;
      {busy_s1, busy_s2} <= 2'h0;
      {rdt_s1, rdt_s2, rdt_s3} <= 3'h0;
      {rst_s1, rst_s2, rst_s3} <= 3'h0;
      soft_rst_ff <= 1'b0;
    end else begin
      {sync_s1, sync_s2, sync_d_ff} <= {I_SYNC_N, sync_s1, sync_s2};
      // a cut frame drops the access at once, the link clock may stay still
      {busy_s1, busy_s2} <= {busy_ff && frame_ff, busy_s1};
      {rdt_s1, rdt_s2, rdt_s3} <= {rd_tog_ff, rdt_s1, rdt_s2};
      {rst_s1, rst_s2, rst_s3} <= {rst_tog_ff, rst_s1, rst_s2};
      soft_rst_ff <= rst_s2 ^ rst_s3;
    end
  end

  // sync hold drops on the falling edge after sync is seen high
  always_ff @(negedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      mod_hold_ff <= 1'b1;
    end else begin
      mod_hold_ff <= !sync_s2;
    end
  end

  // settings register; any reset returns the defaults
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      cfg_ff <= CFG_RST;
    end else if (soft_rst_ff) begin
      cfg_ff <= CFG_RST;
    end else if (I_CFG_WR) begin
      cfg_ff <= I_CFG;
    end
  end

  // conversion sequencer
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      st_ff <= ST_SETTLE;
      chan_ff <= 4'h0;
      wake_cnt_ff <= '0;
    end else if (soft_rst_ff) begin
      // restart continuous conversion from defaults
      st_ff <= ST_SETTLE;
      chan_ff <= 4'h0;
      wake_cnt_ff <= '0;
    end else if (I_CFG_WR) begin
      chan_ff <= first_new[3:0];
      if (I_CFG.op_select == MODE_SINGLE) begin
        st_ff <= ST_WAKE;
        wake_cnt_ff <= WW'(WAKE_CYC - 1);
      end else if (I_CFG.op_select == MODE_CONT) begin
        st_ff <= ST_SETTLE;
      end else begin
        // idle, power-down and calibration codes all stop here
        st_ff <= ST_PDOWN;
      end
    end else if (!sync_s2 && (st_ff == ST_CONV || st_ff == ST_SETTLE)) begin
      // held in a known state, first channel again on release
      st_ff <= ST_SETTLE;
      chan_ff <= first_cfg[3:0];
    end else begin
      unique case (st_ff)
        ST_PDOWN: begin
          // waits for a settings write
        end
        ST_WAKE: begin
          if (wake_cnt_ff == '0) begin
            st_ff <= ST_SETTLE;
          end else begin
            wake_cnt_ff <= wake_cnt_ff - WW'(1);
          end
        end
        ST_SETTLE: begin
          // filter counts its own settling once released
          if (!mod_hold_ff) st_ff <= ST_CONV;
        end
        ST_CONV: begin
          if (I_CONV_DONE) begin
            if (cfg_ff.op_select == MODE_SINGLE && nx_chan[4]) begin
              st_ff <= ST_PDOWN;
            end else if (nx_chan[3:0] != chan_ff) begin
              // new channel: reset modulator and filter again
              chan_ff <= nx_chan[3:0];
              st_ff <= ST_SETTLE;
            end
          end
        end
      endcase
    end
  end

  // next stored word: status carries channel and parity
  always_comb begin
    nxt_result.data = hold_data_ff;
    nxt_result.status = {3'h0, 1'b0, hold_chan_ff};
    if (cfg_ff.parity_en) begin
      nxt_result.status[4] = ^{hold_data_ff, hold_chan_ff};
    end
    nxt_result.append = cfg_ff.status_append_en;
  end

  // data register and ready flag; update beats a read-done clear
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      upd_pend_ff <= 1'b0;
      hold_data_ff <= 24'h000000;
      hold_chan_ff <= 4'h0;
      data_reg_ff <= '0;
      new_tog_ff <= 2'h0;
      rdy_n_ff <= 1'b1;
    end else if (soft_rst_ff) begin
      upd_pend_ff <= 1'b0;
      data_reg_ff <= '0;
      rdy_n_ff <= 1'b1;
    end else begin
      upd_pend_ff <= conv_take;
      if (conv_take) begin
        hold_data_ff <= I_CONV_DATA;
        hold_chan_ff <= chan_ff;
      end
      if (conv_take) begin
        rdy_n_ff <= 1'b1;
      end else if (upd_pend_ff && !busy_s2) begin
        rdy_n_ff <= 1'b0;
      end else if (rd_done) begin
        rdy_n_ff <= 1'b1;
      end
      // a word in a one-shot read is protected; the new one is lost
      if (upd_pend_ff && !busy_s2) begin
        data_reg_ff <= nxt_result;
        // gray step, so two updates without link clocks still differ
        new_tog_ff <= {new_tog_ff[0], !new_tog_ff[1]};
      end
    end
  end

  // clock source and converter outputs
  assign O_CLKSRC_SEL = cfg_ff.clock_source_sel;
  assign O_XTAL_EN = cfg_ff.clock_source_sel == CLKSEL_XTAL;
  assign O_CLKB_OE = cfg_ff.clock_source_sel == CLKSEL_INT_OUT;
  // forwarded clock is gated, not registered
  assign O_CLKB_OUT = O_CLKB_OE & I_INT_OSC_CLK;
  assign O_CFG = cfg_ff;
  assign O_CHAN = chan_ff;
  assign O_MOD_RESET = mod_hold_ff || st_ff == ST_SETTLE || soft_rst_ff;
  assign O_POWER_DOWN = st_ff == ST_PDOWN;
  assign O_OSC_EN = st_ff != ST_PDOWN;

  // ---------------- serial clock domain ----------------
  ser_state_e sst_ff; // serial state
  logic [7:0] sh_in_ff; // input byte shifter
  logic [2:0] incnt_ff; // input bit in byte
  logic [31:0] sh_out_ff; // output shifter, msb on the pin
  logic [5:0] outcnt_ff, len_ff; // output bit count and length
  logic shifting_ff; // a word is on the pin
  logic [5:0] ones_ff; // consecutive ones seen
  logic [1:0] new_s1, new_s2, new_seen_ff; // new-data gray count crossing
  logic ones_hit, byte_end, out_last, cut_rd;
  logic [7:0] in_byte;
  logic [2:0] cur_cnt; // bit in byte, zero on a frame's first edge
  ser_state_e cur_st; // state as this edge sees it

  assign ones_hit = !I_CS_N && I_DIN && ones_ff == RESET_ONES - 6'h01;
  assign in_byte = {sh_in_ff[6:0], I_DIN};
  assign cut_rd = !frame_ff && sst_ff == SS_RDATA;
  assign cur_cnt = frame_ff ? incnt_ff : 3'h0;
  assign cur_st = cut_rd ? SS_CMD : sst_ff;
  assign byte_end = cur_cnt == 3'h7;

  // frame marker; no link clock between frames, so select rising clears it
  always_ff @(posedge I_SCLK or posedge I_RST or posedge I_CS_N) begin
    if (I_RST || I_CS_N) begin
      frame_ff <= 1'b0;
    end else begin
      frame_ff <= 1'b1;
    end
  end
  assign out_last = outcnt_ff == len_ff - 6'h01;

  // new-data toggle crossing; advances only while the host clocks
  always_ff @(posedge I_SCLK or posedge I_RST) begin
    if (I_RST) begin
      {new_s1, new_s2} <= 4'h0;
    end else begin
      {new_s1, new_s2} <= {new_tog_ff, new_s1};
    end
  end

  // run of ones on the data input
  always_ff @(posedge I_SCLK or posedge I_RST) begin
    if (I_RST) begin
      ones_ff <= 6'h00;
      rst_tog_ff <= 1'b0;
    end else if (!I_CS_N) begin
      if (ones_hit) begin
        ones_ff <= 6'h00;
        rst_tog_ff <= !rst_tog_ff;
      end else begin
        ones_ff <= I_DIN ? ones_ff + 6'h01 : 6'h00;
      end
    end
  end

  // command decode and word shifting
  always_ff @(posedge I_SCLK or posedge I_RST) begin
    if (I_RST) begin
      sst_ff <= SS_CMD;
      sh_in_ff <= 8'h00;
      incnt_ff <= 3'h0;
      sh_out_ff <= 32'h00000000;
      outcnt_ff <= 6'h00;
      len_ff <= LEN_DATA;
      shifting_ff <= 1'b0;
      busy_ff <= 1'b0;
      rd_tog_ff <= 1'b0;
      new_seen_ff <= 2'h0;
    end else if (I_CS_N) begin
      // deselect aborts a one-shot read and realigns bytes
      incnt_ff <= 3'h0;
      busy_ff <= 1'b0;
      if (sst_ff == SS_RDATA) begin
        sst_ff <= SS_CMD;
        shifting_ff <= 1'b0;
      end
    end else if (ones_hit) begin
      sst_ff <= SS_CMD;
      incnt_ff <= 3'h0;
      shifting_ff <= 1'b0;
      busy_ff <= 1'b0;
    end else begin
      sh_in_ff <= in_byte;
      incnt_ff <= cur_cnt + 3'h1;
      if (cut_rd) begin
        // read cut by deselect: this edge opens a fresh command
        sst_ff <= SS_CMD;
        shifting_ff <= 1'b0;
        busy_ff <= 1'b0;
      end
      unique case (cur_st)
        SS_CMD: begin
          if (byte_end && in_byte == CMD_RD_DATA) begin
            // same word may be fetched again by another command
            sst_ff <= SS_RDATA;
            sh_out_ff <= {data_reg_ff.data, data_reg_ff.status};
            len_ff <= data_reg_ff.append ? LEN_STAT : LEN_DATA;
            outcnt_ff <= 6'h00;
            shifting_ff <= 1'b1;
            busy_ff <= 1'b1;
            new_seen_ff <= new_s2;
          end else if (byte_end && in_byte == CMD_CREAD) begin
            sst_ff <= SS_CREAD;
            new_seen_ff <= new_s2;
          end
        end
        SS_RDATA: begin
          sh_out_ff <= {sh_out_ff[30:0], 1'b0};
          outcnt_ff <= outcnt_ff + 6'h01;
          if (out_last) begin
            sst_ff <= SS_CMD;
            shifting_ff <= 1'b0;
            busy_ff <= 1'b0;
            incnt_ff <= 3'h0;
            rd_tog_ff <= !rd_tog_ff;
          end
        end
        SS_CREAD: begin
          if (new_s2 != new_seen_ff) begin
            // fresh result replaces any partly read word
            sh_out_ff <= {data_reg_ff.data, data_reg_ff.status};
            len_ff <= data_reg_ff.append ? LEN_STAT : LEN_DATA;
            outcnt_ff <= 6'h00;
            shifting_ff <= 1'b1;
            new_seen_ff <= new_s2;
          end else if (shifting_ff) begin
            sh_out_ff <= {sh_out_ff[30:0], 1'b0};
            outcnt_ff <= outcnt_ff + 6'h01;
            if (out_last) begin
              shifting_ff <= 1'b0;
              rd_tog_ff <= !rd_tog_ff;
            end
          end
          if (byte_end && in_byte == CMD_RD_DATA) begin
            sst_ff <= SS_CMD;
            shifting_ff <= 1'b0;
          end
        end
        default: sst_ff <= SS_CMD;
      endcase
    end
  end

  // pin shows the word while shifting, else the ready flag
  assign O_DOUT_RDY_N = (shifting_ff && !cut_rd) ? sh_out_ff[31] : rdy_n_ff;
  assign O_DOUT_OE = !I_CS_N;

  // ---------------- checks ----------------
  wake_start_a: assert property (
    @(posedge I_CLK) disable iff (I_RST)
    (I_CFG_WR && I_CFG.op_select == MODE_SINGLE && !soft_rst_ff)
    |=> st_ff == ST_WAKE && wake_cnt_ff == WW'(WAKE_CYC - 1) && !O_POWER_DOWN)
    else $error("single write did not start wake");
  rdy_pre_upd_a: assert property (
    @(posedge I_CLK) disable iff (I_RST)
    (conv_take && !soft_rst_ff) |=> rdy_n_ff && upd_pend_ff)
    else $error("ready not raised before update");
  upd_rdy_low_a: assert property (
    @(posedge I_CLK) disable iff (I_RST)
    (upd_pend_ff && !busy_s2 && !soft_rst_ff)
    |=> !rdy_n_ff && new_tog_ff != $past(new_tog_ff))
    else $error("update did not signal ready");
  busy_drop_a: assert property (
    @(posedge I_CLK) disable iff (I_RST)
    (upd_pend_ff && busy_s2 && !soft_rst_ff) |=> $stable(data_reg_ff))
    else $error("data changed during access");
  single_end_a: assert property (
    @(posedge I_CLK) disable iff (I_RST)
    (conv_take && cfg_ff.op_select == MODE_SINGLE && nx_chan[4] && sync_s2
     && !I_CFG_WR && !soft_rst_ff) |=> st_ff == ST_PDOWN ##1 O_POWER_DOWN)
    else $error("single pass did not power down");
  chan_switch_a: assert property (
    @(posedge I_CLK) disable iff (I_RST)
    (conv_take && nx_chan[3:0] != chan_ff && sync_s2 && !I_CFG_WR && !soft_rst_ff
     && !(cfg_ff.op_select == MODE_SINGLE && nx_chan[4])) |=> O_MOD_RESET)
    else $error("channel switch without filter reset");
  status_chan_a: assert property (
    @(posedge I_CLK) disable iff (I_RST)
    (upd_pend_ff && !busy_s2 && !soft_rst_ff)
    |=> data_reg_ff.status[3:0] == $past(hold_chan_ff)
        && data_reg_ff.data == $past(hold_data_ff))
    else $error("status channel mismatch");
  parity_even_a: assert property (
    @(posedge I_CLK) disable iff (I_RST)
    (upd_pend_ff && !busy_s2 && cfg_ff.parity_en && !soft_rst_ff)
    |=> !(^{data_reg_ff.data, data_reg_ff.status}))
    else $error("odd count of ones");
  sync_hold_a: assert property (
    @(posedge I_CLK) disable iff (I_RST)
    !sync_s2 [*2] |-> O_MOD_RESET && st_ff != ST_CONV)
    else $error("sync low without filter reset");
  ones_rst_a: assert property (
    @(posedge I_SCLK) disable iff (I_RST)
    ones_hit |=> sst_ff == SS_CMD && !shifting_ff && ones_ff == 6'h00
    && rst_tog_ff != $past(rst_tog_ff))
    else $error("forty ones did not reset interface");
  cread_load_a: assert property (
    @(posedge I_SCLK) disable iff (I_RST)
    (!I_CS_N && !ones_hit && sst_ff == SS_CREAD && new_s2 != new_seen_ff
     && !(byte_end && in_byte == CMD_RD_DATA)) |=> shifting_ff && outcnt_ff == 6'h00)
    else $error("new word not loaded in continuous read");
  single_pass_c: cover property (@(posedge I_CLK) disable iff (I_RST)
    st_ff == ST_CONV ##1 st_ff == ST_SETTLE ##[1:1000] st_ff == ST_PDOWN);
  discard_c: cover property (@(posedge I_CLK) disable iff (I_RST)
    upd_pend_ff && busy_s2);
  cread_c: cover property (@(posedge I_SCLK) disable iff (I_RST)
    sst_ff == SS_CREAD && shifting_ff && out_last);
endmodule
`default_nettype wire

// file: core/adc_mode_pkg.sv
package adc_mode_pkg;
  // system clock rate and oscillator wake time
  localparam int CLK_MHZ = 200;
  localparam int OSC_WAKE_MS = 1;
  // least wait, exact at this rate
  localparam int OSC_WAKE_CYC = OSC_WAKE_MS * CLK_MHZ * 1000;

  // serial input reset: consecutive ones on the data input
  localparam logic [5:0] RESET_ONES = 6'h28;

  // communications byte codes
  localparam logic [7:0] CMD_RD_DATA = 8'h58;
  localparam logic [7:0] CMD_CREAD = 8'h5C;

  // operating-mode codes
  localparam logic [2:0] MODE_CONT = 3'h0;
  localparam logic [2:0] MODE_SINGLE = 3'h1;

  // clock-source codes
  localparam logic [1:0] CLKSEL_XTAL = 2'h0;
  localparam logic [1:0] CLKSEL_EXT = 2'h1;
  localparam logic [1:0] CLKSEL_INT = 2'h2;
  localparam logic [1:0] CLKSEL_INT_OUT = 2'h3;

  // output word lengths in bits
  localparam logic [5:0] LEN_DATA = 6'h18;
  localparam logic [5:0] LEN_STAT = 6'h20;

  // settings written by the host side
  typedef struct packed {
    logic [2:0] op_select;
    logic status_append_en;
    logic parity_en;
    logic [1:0] clock_source_sel;
    logic [7:0] chan_en;
  } cfg_s;

  // settings after any reset
  localparam cfg_s CFG_RST = '{MODE_CONT, 1'b0, 1'b0, CLKSEL_INT, 8'h01};

  // one stored result
  typedef struct packed {
    logic [23:0] data;
    logic [7:0] status;
    logic append;
  } result_s;

  // conversion sequencer states
  typedef enum logic [1:0] {
    ST_PDOWN = 2'b00,
    ST_WAKE = 2'b01,
    ST_SETTLE = 2'b10,
    ST_CONV = 2'b11
  } seq_state_e;

  // serial interface states
  typedef enum logic [1:0] {
    SS_CMD = 2'b00,
    SS_RDATA = 2'b01,
    SS_CREAD = 2'b10
  } ser_state_e;
endpackage

// file: verification/adc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// host serial port; its clock runs inside frames, and for two edges during reset
module adc_host_model
  import adc_mode_pkg::*;
#(
  parameter int RST_WAIT_NS = 200 // short stand-in for the long post-reset wait
) (
  // serial pins
  input wire logic i_dout,
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_din
);
  // idle: clock still, deselected, data low
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_din = 1'b0;
  end
  // one clock: data set while low, pin taken just before the rise
  task automatic tick(input logic d, output logic q);
    o_din = d;
    #3;
    q = i_dout;
    o_sclk = 1'b1;
    #3;
    o_sclk = 1'b0;
  endtask
  // open or close a frame, data parked low
  task automatic sel(input logic on);
    #3;
    o_cs_n = !on;
    o_din = 1'b0;
    #3;
  endtask
  // command byte, msb first
  task automatic cmd(input logic [7:0] b);
    logic q;
    for (int i = 7; i >= 0; i--) tick(b[i], q);
    o_din = 1'b0;
  endtask
  // shift n bits in with data low
  task automatic bits(input int n, inout logic [31:0] w);
    logic q;
    for (int i = 0; i < n; i++) begin
      tick(1'b0, q);
      w = {w[30:0], q};
    end
  endtask
  // one-shot read of the data word
  task automatic rd(input int n, output logic [31:0] w);
    w = '0;
    sel(1'b1);
    cmd(CMD_RD_DATA);
    bits(n, w);
    sel(1'b0);
  endtask
  // bounded wait for ready low while selected
  task automatic wlow(output logic ok);
    ok = 1'b0;
    for (int i = 0; i < 400 && !ok; i++) #1 ok = (i_dout === 1'b0);
  endtask
  // forty ones, then the settling wait
  task automatic ones();
    logic q;
    for (int i = 0; i < 40; i++) tick(1'b1, q);
    o_din = 1'b0;
    #(RST_WAIT_NS);
  endtask
endmodule
`default_nettype wire

// file: verification/adc_conversion_mode_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_mode_control_tb;
  import adc_mode_pkg::*;
  localparam int WK = 20; // short oscillator wake
  // design side signals
  logic clk, rst, sync_n, cfg_wr, done, osc;
  logic [23:0] cdata;
  cfg_s cfg_in, cfg_out;
  logic [3:0] chan;
  logic [1:0] csel;
  logic rdy_n, oe, mres, pdn, osc_en, xtal, clkb, clkb_oe;
  wire logic sclk, cs_n, din, dpin;
  logic [31:0] w; // last shifted word
  int error_cnt = 0;
  int samples_checked = 0;
  logic dlast = 1'b1; // last level the design drove on the pin
  // pin floats when deselected, no pull: show the inverse of the last level
  always @(oe or rdy_n) begin
    if (oe) dlast = rdy_n;
  end
  assign dpin = oe ? rdy_n : !dlast;
  adc_mode_ctrl #(.WAKE_CYC(WK)) DUT (
    .I_CLK(clk), .I_RST(rst), .I_SCLK(sclk), .I_CS_N(cs_n), .I_DIN(din),
    .O_DOUT_RDY_N(rdy_n), .O_DOUT_OE(oe), .I_SYNC_N(sync_n), .I_CFG_WR(cfg_wr),
    .I_CFG(cfg_in), .O_CFG(cfg_out), .I_CONV_DONE(done), .I_CONV_DATA(cdata),
    .O_CHAN(chan), .O_MOD_RESET(mres), .O_POWER_DOWN(pdn), .O_OSC_EN(osc_en),
    .I_INT_OSC_CLK(osc), .O_CLKSRC_SEL(csel), .O_XTAL_EN(xtal), .O_CLKB_OUT(clkb),
    .O_CLKB_OE(clkb_oe));
  adc_host_model host (.i_dout(dpin), .o_sclk(sclk), .o_cs_n(cs_n), .o_din(din));
  // master clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = !clk;
  end
  // internal oscillator, edges land on master clock edges
  initial begin
    osc = 1'b0;
    forever #100 osc = !osc;
  end
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  // verdict and end of run
  task automatic finish_test();
    $display("checked %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // one-cycle settings write
  task automatic setcfg(input cfg_s c);
    @(posedge clk);
    cfg_wr <= 1'b1;
    cfg_in <= c;
    @(posedge clk);
    cfg_wr <= 1'b0;
    cyc(2);
  endtask
  // filter result, given once modulator reset and power-down are both low
  task automatic conv(input logic [23:0] d);
    int i;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while ((mres !== 1'b0 || pdn !== 1'b0) && i < 500);
    chk(i < 500, 1);
    done <= 1'b1;
    cdata <= d;
    @(posedge clk);
    done <= 1'b0;
    cyc(8);
  endtask
  task automatic t_reset();
    chk(cfg_out, CFG_RST);
    chk({pdn, osc_en, oe}, 3'b010);
    $display("test reset done");
  endtask
  task automatic t_clk();
    for (int k = 0; k < 4; k++) begin
      setcfg(cfg_s'{MODE_CONT, 1'b0, 1'b0, 2'(k), 8'h01});
      chk({csel, xtal, clkb_oe, clkb}, {2'(k), k == 0, k == 3, (k == 3) && osc});
      #100;
      chk(clkb, (k == 3) && osc);
    end
    $display("test clock select done");
  endtask
  // ready, read, re-read, and a result lost to a read in flight
  task automatic t_read();
    conv(24'hA5C3F1);
    chk(oe, 0);
    host.sel(1'b1);
    chk(dpin, 0);
    host.cmd(CMD_RD_DATA);
    host.bits(24, w);
    #30;
    chk({dpin, w[23:0]}, {1'b1, 24'hA5C3F1});
    host.sel(1'b0);
    host.rd(24, w);
    chk(w[23:0], 24'hA5C3F1);
    host.sel(1'b1);
    host.cmd(CMD_RD_DATA);
    host.bits(4, w);
    conv(24'h0F0F0F);
    host.bits(20, w);
    host.sel(1'b0);
    host.rd(24, w);
    chk(w[23:0], 24'hA5C3F1);
    $display("test read done");
  endtask
  // two channels, status and parity appended
  task automatic t_seq();
    logic [23:0] d;
    setcfg(cfg_s'{MODE_CONT, 1'b1, 1'b1, CLKSEL_INT, 8'h05});
    for (int i = 0; i < 2; i++) begin
      d = i ? 24'h800001 : 24'h7FFFFE;
      chk(chan, 4'(i * 2));
      conv(d);
      chk(chan, 4'(2 - i * 2));
      host.rd(32, w);
      chk(w, {d, 3'b000, ^{d, 4'(i * 2)}, 4'(i * 2)});
    end
    $display("test sequencer done");
  endtask
  task automatic t_single();
    setcfg(cfg_s'{MODE_SINGLE, 1'b0, 1'b0, CLKSEL_INT, 8'h03});
    chk({pdn, osc_en}, 2'b01);
    cyc(WK + 2);
    conv(24'h111111);
    chk(chan, 1);
    conv(24'h222222);
    chk({pdn, osc_en}, 2'b10);
    host.rd(24, w);
    chk(w[23:0], 24'h222222);
    setcfg(cfg_s'{3'h3, 1'b0, 1'b0, CLKSEL_INT, 8'h03});
    chk({pdn, osc_en}, 2'b10);
    $display("test single done");
  endtask
  task automatic t_sync();
    setcfg(cfg_s'{MODE_CONT, 1'b1, 1'b0, CLKSEL_XTAL, 8'h06});
    conv(24'h333333);
    sync_n <= 1'b0;
    cyc(6);
    chk({mres, chan, cfg_out.chan_en}, 13'h1106);
    sync_n <= 1'b1;
    cyc(6);
    chk(mres, 0);
    conv(24'h444444);
    host.rd(32, w);
    chk(w, 32'h44444401);
    $display("test sync done");
  endtask
  // continuous read: auto words, overrun, exit
  task automatic t_cread();
    logic ok;
    setcfg(cfg_s'{MODE_CONT, 1'b0, 1'b0, CLKSEL_INT, 8'h01});
    host.sel(1'b1);
    host.cmd(CMD_CREAD);
    conv(24'h555555);
    host.wlow(ok);
    host.bits(27, w);
    chk({ok, w[23:0]}, {1'b1, 24'h555555});
    conv(24'h666666);
    conv(24'h777777);
    host.wlow(ok);
    host.bits(27, w);
    chk({ok, w[23:0]}, {1'b1, 24'h777777});
    host.sel(1'b0);
    host.sel(1'b1);
    conv(24'h888888);
    host.wlow(ok);
    host.cmd(CMD_RD_DATA);
    host.sel(1'b0);
    host.rd(24, w);
    chk({ok, w[23:0]}, {1'b1, 24'h888888});
    $display("test continuous read done");
  endtask
  task automatic t_ones();
    setcfg(cfg_s'{MODE_SINGLE, 1'b1, 1'b1, CLKSEL_EXT, 8'hF0});
    host.sel(1'b1);
    host.cmd(CMD_CREAD);
    host.ones();
    host.sel(1'b0);
    chk({cfg_out, pdn}, {CFG_RST, 1'b0});
    host.rd(24, w);
    chk(w[23:0], 24'h000000);
    $display("test ones reset done");
  endtask
  // main sequence
  initial begin
    rst = 1'b1;
    sync_n = 1'b1;
    cfg_wr = 1'b0;
    cfg_in = CFG_RST;
    done = 1'b0;
    cdata = '0;
    host.bits(2, w);
    cyc(16);
    rst <= 1'b0;
    cyc(4);
    t_reset();
    t_clk();
    t_read();
    t_seq();
    t_single();
    t_sync();
    t_cread();
    t_ones();
    finish_test();
  end
  // hang guard, well past the few microseconds the tests need
  initial begin
    #100000;
    error_cnt++;
    finish_test();
  end
endmodule
`default_nettype wire
